//--- hw/itsu_top.sv
// Trigger detection, interrupt steering and external controller select
`timescale 1ns/1ns
`include "itsu_cfg.svh"

module itsu_top (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic [15:0]             irq_native,
    input  wire logic [3:0]              pci_irq_lines_n,
    input  wire logic [7:0]              pci_route_ctl [4],
    input  wire logic                    board_irq_0_in,
    input  wire logic [7:0]              board_irq_route_ctl,
    input  wire logic                    timer_irq0,
    input  wire logic                    usb_enable,
    input  wire logic                    usb_irq,
    input  wire logic [7:0]              init_word_one,
    input  wire logic                    els_master_we,
    input  wire logic                    els_slave_we,
    input  wire logic [7:0]              els_wdata,
    input  wire logic [15:0]             irq_mask,
    input  wire logic [15:0]             eoi_clear,
    input  wire itsu_pkg::itsu_pci_cyc_t pci_cyc,
    input  wire logic [31:8]             ext_intc_base_addr,
    input  wire logic                    ext_intc_sel_en,
    output logic [7:0]                   edge_level_sel_master,
    output logic [7:0]                   edge_level_sel_slave,
    output logic [15:0]                  irq_pending,
    output logic [15:0]                  in_service_bits,
    output logic                         intr,
    output logic [3:0]                   ack_vector,
    output logic                         ack_valid,
    output logic                         ack_default,
    output logic                         board_irq_0_out,
    output logic                         board_irq_0_oe,
    output logic                         pci_irq_line_d_out,
    output logic                         pci_irq_line_d_oe,
    output logic                         ext_intc_select_n,
    output itsu_pkg::itsu_isa_addr_t     isa_addr,
    output itsu_pkg::itsu_xcvr_t         xcvr
);
    import itsu_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [15:0] native_s1;
    logic [15:0] native_s2;
    logic [3:0]  pci_s1;
    logic [3:0]  pci_s2;
    logic        board_s1;
    logic        board_s2;

    // Reset to idle levels so that no false edge follows reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            native_s1 <= 16'h0000;
            native_s2 <= 16'h0000;
            pci_s1    <= 4'hf;
            pci_s2    <= 4'hf;
            board_s1  <= 1'b0;
            board_s2  <= 1'b0;
        end else begin
            native_s1 <= irq_native;
            native_s2 <= native_s1;
            pci_s1    <= pci_irq_lines_n;
            pci_s2    <= pci_s1;
            board_s1  <= board_irq_0_in;
            board_s2  <= board_s1;
        end
    end

    // ************************************************************
    // Edge/level selection
    // ************************************************************
    // init_word_one bit 3 is deliberately never read
    // Locked inputs read back as edge mode whatever software writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            edge_level_sel_master <= `ITSU_ELS_MASTER_RST;
            edge_level_sel_slave  <= `ITSU_ELS_SLAVE_RST;
        end else begin
            if (els_master_we) begin
                edge_level_sel_master <= els_wdata & ~`ITSU_ELS_MASTER_LOCK;
            end
            if (els_slave_we) begin
                edge_level_sel_slave <= els_wdata & ~`ITSU_ELS_SLAVE_LOCK;
            end
        end
    end

    // ************************************************************
    // USB share of PCI line d
    // ************************************************************
    logic usb_drive;

    // Drives the line inside the block as well as at the pin
    assign usb_drive = usb_enable && usb_irq;

    // ************************************************************
    // Steering
    // ************************************************************
    logic [3:0]  pci_active;
    logic [15:0] routed;
    logic [15:0] combined;
    logic [15:0] level_sel;
    logic        board_pin_is_out;
    logic [15:0] route_ok;

    assign board_pin_is_out = board_irq_route_ctl[`ITSU_BOARD_IRQ0_OUT];
    // Only 15, 14, 12-9 and 7-3 may receive a steered line
    assign route_ok         = `ITSU_ROUTE_OK_MASK;
    assign pci_active       = ~pci_s2 | {usb_drive, 3'b000};
    assign level_sel        = {edge_level_sel_slave, edge_level_sel_master};

    always_comb begin
        routed = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            if (!pci_route_ctl[i][`ITSU_ROUTE_DIS_BIT]) begin
                // Targets outside the allowed set are dropped
                for (int n = 0; n < `ITSU_IRQ_COUNT; n++) begin
                    if (pci_route_ctl[i][`ITSU_ROUTE_IRQ_MSB:0] == n[3:0]
                        && route_ok[n]) begin
                        routed[n] = routed[n] | pci_active[i];
                    end
                end
            end
        end
        // Board line is active high; as output it routes nothing
        if (!board_irq_route_ctl[`ITSU_ROUTE_DIS_BIT] && !board_pin_is_out) begin
            for (int n = 0; n < `ITSU_IRQ_COUNT; n++) begin
                if (board_irq_route_ctl[`ITSU_ROUTE_IRQ_MSB:0] == n[3:0]
                    && route_ok[n]) begin
                    routed[n] = routed[n] | board_s2;
                end
            end
        end
        combined = native_s2 | routed;
        combined[0] = timer_irq0;       // Timer owns interrupt 0
        combined[`ITSU_CASCADE_IRQ] = 1'b0;
    end

    // ************************************************************
    // Trigger detection
    // ************************************************************
    logic [15:0] combined_q;
    logic [15:0] edge_latch;
    logic [15:0] ack_take;

    // Last cycle's lines, so that a line held high raises no new request
    always_ff @(posedge clk) begin
        if (!nrst) begin
            combined_q <= 16'h0000;
        end else begin
            combined_q <= combined;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_trig
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    edge_latch[g] <= 1'b0;
                end else if (combined[g] && !combined_q[g]) begin
                    edge_latch[g] <= 1'b1;  // new edge wins over acknowledge
                end else if (ack_take[g] || !combined[g]) begin
                    // Edge request is lost if the line drops before acknowledge
                    edge_latch[g] <= 1'b0;
                end
            end
            // Level mode: high level pending, no edge needed
            assign irq_pending[g] = (level_sel[g] ? combined[g] : edge_latch[g])
                                    && !in_service_bits[g];
        end
    endgenerate

    // ************************************************************
    // Priority and cascade
    // ************************************************************
    logic [15:0] eligible;
    logic        slave_req;
    logic [3:0]  best;
    logic        any_req;

    assign eligible = irq_pending & ~irq_mask;
    assign slave_req = |eligible[15:8];

    always_comb begin
        best    = 4'h0;
        any_req = 1'b0;
        // Master order 0,1,then slave via 2, then 3..7
        for (int n = 7; n >= 0; n--) begin
            if (n == `ITSU_CASCADE_IRQ && slave_req) begin
                for (int s = 15; s >= 8; s--) begin
                    if (eligible[s]) begin
                        best    = s[3:0];
                        any_req = 1'b1;
                    end
                end
            end else if (eligible[n]) begin
                best    = n[3:0];
                any_req = 1'b1;
            end
        end
    end

    // ************************************************************
    // Acknowledge sequence
    // ************************************************************
    itsu_ack_state_t state;
    logic            ack_start;

    // Sources must hold until frame and irdy both assert
    assign ack_start = pci_cyc.inta_cycle && !pci_cyc.frame_n && !pci_cyc.irdy_n;
    assign intr      = any_req;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ITSU_IDLE;
        end else begin
            case (state)
                ITSU_IDLE: begin
                    if (ack_start) begin
                        state <= ITSU_ACK;
                    end
                end
                ITSU_ACK:  state <= ITSU_HELD;
                // New acknowledges are refused until the bus goes idle again
                ITSU_HELD: begin
                    if (pci_cyc.frame_n && pci_cyc.irdy_n) begin
                        state <= ITSU_IDLE;
                    end
                end
                default:   state <= ITSU_IDLE;
            endcase
        end
    end

    always_comb begin
        ack_take = 16'h0000;
        if (state == ITSU_IDLE && ack_start && any_req) begin
            ack_take[best] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_vector  <= 4'h0;
            ack_valid   <= 1'b0;
            ack_default <= 1'b0;
        end else begin
            ack_valid <= state == ITSU_IDLE && ack_start;
            if (state == ITSU_IDLE && ack_start) begin
                ack_vector  <= any_req ? best : `ITSU_DEFAULT_IRQ_H;
                ack_default <= !any_req;
            end
        end
    end

    // In-service: set by genuine acknowledge only; level sources clear first
    always_ff @(posedge clk) begin
        if (!nrst) begin
            in_service_bits <= 16'h0000;
        end else begin
            // Set wins over a simultaneous end-of-interrupt clear
            in_service_bits <= (in_service_bits & ~eoi_clear) | ack_take;
        end
    end

    // ************************************************************
    // Pins: board irq 0 and PCI line d
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            board_irq_0_out    <= 1'b0;
            board_irq_0_oe     <= 1'b0;
            pci_irq_line_d_out <= 1'b1;
            pci_irq_line_d_oe  <= 1'b0;
        end else begin
            board_irq_0_oe     <= board_pin_is_out;
            // Timer copy is registered like every other pin output except intr and irq_pending
            board_irq_0_out    <= timer_irq0;
            // Open-drain style: drive low only while USB requests
            pci_irq_line_d_out <= 1'b0;
            pci_irq_line_d_oe  <= usb_drive;
        end
    end

    // ************************************************************
    // External interrupt controller select
    // ************************************************************
    logic       hit;
    logic [1:0] sa_low;

    assign hit = ext_intc_sel_en && pci_cyc.mem_cycle && !pci_cyc.isa_origin
                 && !pci_cyc.frame_n && pci_cyc.addr[31:8] == ext_intc_base_addr;
    // Lowest enabled byte lane gives the two low address bits
    assign sa_low = {pci_cyc.cbe_n[1] & pci_cyc.cbe_n[0],
                     pci_cyc.cbe_n[0] & (!pci_cyc.cbe_n[1] | pci_cyc.cbe_n[2])};
    // Registered, so select and transceiver controls trail the address by a clock

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_intc_select_n <= 1'b1;
            isa_addr          <= '0;
            xcvr              <= 4'b1110;
        end else begin
            ext_intc_select_n <= !hit;
            isa_addr.drive    <= hit;   // Cycle still forwarded to ISA
            isa_addr.la       <= 7'h00;
            isa_addr.sa       <= hit ? {4'h0, pci_cyc.addr[15:2], sa_low}
                                     : 20'h00000;
            xcvr.xbus_xcvr_oe_n  <= !hit;
            xcvr.xbus_xcvr_dir_n <= !hit;
            xcvr.disk_xcvr_oe_n  <= !hit;
            xcvr.disk_xcvr_dir   <= 1'b0;
        end
    end

endmodule // itsu_top

//--- pkg/itsu_cfg.svh
// Constants for the interrupt trigger and steering unit
`ifndef ITSU_CFG_SVH
`define ITSU_CFG_SVH

// ************************************************************
// Edge/level reset values and locked inputs
// ************************************************************
`define ITSU_ELS_MASTER_RST  8'h00
`define ITSU_ELS_SLAVE_RST   8'h00
// Inputs 0, 1, 2 (master) and 8, 13 (slave) stay edge mode
`define ITSU_ELS_MASTER_LOCK 8'h07
`define ITSU_ELS_SLAVE_LOCK  8'h21

// ************************************************************
// Route control fields
// ************************************************************
`define ITSU_ROUTE_DIS_BIT   7
`define ITSU_ROUTE_IRQ_MSB   3
// Bit 5 of the first board route register drives timer irq 0 out
`define ITSU_BOARD_IRQ0_OUT  5
// Interrupt numbers that may be steering targets
`define ITSU_ROUTE_OK_MASK   16'hdef8
`define ITSU_CASCADE_IRQ     2
`define ITSU_DEFAULT_IRQ     7
`define ITSU_DEFAULT_IRQ_H   4'h7
`define ITSU_IRQ_COUNT       16

`endif

//--- pkg/itsu_pkg.sv
// Types for the interrupt trigger and steering unit
package itsu_pkg;

    typedef struct packed {
        logic        frame_n;
        logic        irdy_n;
        logic        inta_cycle;
        logic        mem_cycle;
        logic        isa_origin;
        logic [31:0] addr;
        logic [3:0]  cbe_n;
    } itsu_pci_cyc_t;

    typedef struct packed {
        logic [19:0] sa;
        logic [23:17] la;
        logic        drive;
    } itsu_isa_addr_t;

    typedef struct packed {
        logic xbus_xcvr_oe_n;
        logic xbus_xcvr_dir_n;
        logic disk_xcvr_oe_n;
        logic disk_xcvr_dir;
    } itsu_xcvr_t;

    typedef enum logic [2:0] {
        ITSU_IDLE = 3'b001,
        ITSU_HELD = 3'b010,
        ITSU_ACK  = 3'b100
    } itsu_ack_state_t;

endpackage

//--- verification/itsu_host_model.sv
// Host model: acknowledge and memory cycles on the PCI side
`timescale 1ns/1ns
module itsu_host_model (
    input  wire logic              clk,
    input  wire logic              ack_valid,
    output itsu_pkg::itsu_pci_cyc_t pci_cyc
);
    import itsu_pkg::*;
    initial pci_cyc = '{frame_n: 1'b1, irdy_n: 1'b1, default: '0};
    // Released address and byte enables show the inverse of their last value, not a held copy
    task automatic idle();
        pci_cyc.frame_n = 1'b1;
        pci_cyc.irdy_n = 1'b1;
        pci_cyc.inta_cycle = 1'b0;
        pci_cyc.mem_cycle = 1'b0;
        pci_cyc.addr = ~pci_cyc.addr;
        pci_cyc.cbe_n = ~pci_cyc.cbe_n;
    endtask
    task automatic mem(input logic [31:0] a, input logic isa);
        pci_cyc.addr = a;
        pci_cyc.cbe_n = 4'h0;
        pci_cyc.isa_origin = isa;
        pci_cyc.mem_cycle = 1'b1;
        pci_cyc.frame_n = 1'b0;
        pci_cyc.irdy_n = 1'b0;
    endtask
    // Held until one clock after the answer is seen, then one idle cycle before the next
    task automatic inta();
        int n;
        pci_cyc.inta_cycle = 1'b1;
        pci_cyc.frame_n = 1'b0;
        pci_cyc.irdy_n = 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (ack_valid !== 1'b1 && n < 16);
        @(posedge clk);
        #1;
        idle();
        @(posedge clk);
        #1;
    endtask
endmodule // itsu_host_model

//--- verification/itsu_top_bench.sv
// Self-checking bench for the trigger and steering unit
`timescale 1ns/1ns
module itsu_top_bench;
    import itsu_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, board_irq_0_in = 1'b0, timer_irq0 = 1'b0;
    logic usb_enable = 1'b0, usb_irq = 1'b0, els_master_we = 1'b0, els_slave_we = 1'b0;
    logic ext_intc_sel_en = 1'b0, intr, ack_valid, ack_default, board_irq_0_out;
    logic board_irq_0_oe, pci_irq_line_d_out, pci_irq_line_d_oe, ext_intc_select_n;
    logic [15:0] irq_native = 16'h0000, eoi_clear = 16'h0000, irq_pending, in_service_bits;
    logic [7:0] pci_route_ctl [4] = '{default: 8'h80};
    logic [7:0] board_irq_route_ctl = 8'h80, init_word_one = 8'h00, els_wdata = 8'h00;
    logic [7:0] edge_level_sel_master, edge_level_sel_slave;
    logic [3:0] pci_irq_lines_n = 4'hf, ack_vector;
    logic [31:8] ext_intc_base_addr = 24'h12ab00;
    itsu_pci_cyc_t pci_cyc;
    itsu_isa_addr_t isa_addr;
    itsu_xcvr_t xcvr;
    int n_fail = 0, checks = 0;
    itsu_top dut_u (.clk, .nrst, .irq_native, .pci_irq_lines_n, .pci_route_ctl,
        .board_irq_0_in, .board_irq_route_ctl, .timer_irq0, .usb_enable, .usb_irq,
        .init_word_one, .els_master_we, .els_slave_we, .els_wdata, .irq_mask(16'h0000),
        .eoi_clear, .pci_cyc, .ext_intc_base_addr, .ext_intc_sel_en, .edge_level_sel_master,
        .edge_level_sel_slave, .irq_pending, .in_service_bits, .intr, .ack_vector,
        .ack_valid, .ack_default, .board_irq_0_out, .board_irq_0_oe, .pci_irq_line_d_out,
        .pci_irq_line_d_oe, .ext_intc_select_n, .isa_addr, .xcvr);
    itsu_host_model host_u (.clk, .ack_valid, .pci_cyc);
    always #5 clk = ~clk;
    // ********************
    // Shared tasks
    // ********************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic els(input logic [7:0] d);
        els_wdata = d;
        {els_master_we, els_slave_we} = 2'b11;
        cyc(1);
        {els_master_we, els_slave_we} = 2'b00;
        cyc(1);
    endtask
    task automatic eoi(input logic [15:0] m);
        eoi_clear = m;
        cyc(1);
        eoi_clear = 16'h0000;
        cyc(1);
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic t_els();
        chk({edge_level_sel_master, edge_level_sel_slave}, 16'h0000);
        init_word_one = 8'h18;
        cyc(2);
        chk(edge_level_sel_master, 8'h00);
        els(8'hff);
        chk({edge_level_sel_master, edge_level_sel_slave}, 16'hf8de);
        els(8'h00);
        $display("test els done");
    endtask
    task automatic t_edge(input int n);
        irq_native[n] = 1'b1;
        cyc(3);
        chk({intr, irq_pending[n]}, 2'b11);
        host_u.inta();
        chk({ack_default, ack_vector, in_service_bits[n]}, {1'b0, 4'(n), 1'b1});
        eoi(16'h0001 << n);
        cyc(2);
        chk({intr, irq_pending[n], in_service_bits[n]}, 3'b000);
        irq_native[n] = 1'b0;
        cyc(3);
        $display("test edge %0d done", n);
    endtask
    task automatic t_level();
        els(8'h20);
        irq_native[5] = 1'b1;
        cyc(3);
        host_u.inta();
        chk({ack_vector, irq_pending[5]}, 5'h0a);
        eoi(16'h0020);
        chk(irq_pending[5], 1'b1);
        host_u.inta();
        irq_native[5] = 1'b0;
        cyc(3);
        eoi(16'h0020);
        chk(irq_pending[5], 1'b0);
        els(8'h00);
        $display("test level done");
    endtask
    task automatic t_dflt();
        irq_native[7] = 1'b1;
        cyc(3);
        host_u.inta();
        chk(in_service_bits[7], 1'b1);
        irq_native = 16'h0010;
        cyc(3);
        irq_native = 16'h0000;
        cyc(3);
        host_u.inta();
        chk({ack_default, ack_vector, in_service_bits[7]}, 6'h2f);
        eoi(16'hffff);
        host_u.inta();
        chk({ack_default, ack_vector, in_service_bits}, 21'h170000);
        $display("test default done");
    endtask
    task automatic t_route();
        logic [15:0] exp;
        els(8'hff);
        for (int i = 0; i < 16; i++) begin
            exp = 16'hdef8 & (16'h0001 << i);
            pci_route_ctl[0] = {4'h0, 4'(i)};
            pci_irq_lines_n[0] = 1'b0;
            cyc(3);
            chk(irq_pending & 16'hfffb, exp);
            {pci_irq_lines_n[0], pci_route_ctl[0]} = 9'h180;
            board_irq_route_ctl = {4'h0, 4'(i)};
            board_irq_0_in = 1'b1;
            cyc(3);
            chk(irq_pending & 16'hfffb, exp);
            {board_irq_0_in, board_irq_route_ctl} = 9'h080;
            cyc(3);
        end
        pci_route_ctl = '{8'h0a, 8'h0a, 8'h8a, 8'h8a};
        pci_irq_lines_n = 4'b1101;
        cyc(3);
        chk(irq_pending[10], 1'b1);
        pci_irq_lines_n = 4'b0011;
        cyc(3);
        chk(irq_pending[10], 1'b0);
        {pci_irq_lines_n, pci_route_ctl[3]} = 12'hf06;
        {usb_enable, usb_irq} = 2'b11;
        cyc(3);
        chk({pci_irq_line_d_oe, pci_irq_line_d_out, irq_pending[6]}, 3'b101);
        usb_enable = 1'b0;
        cyc(3);
        chk({pci_irq_line_d_oe, irq_pending[6]}, 2'b00);
        els(8'h00);
        $display("test route done");
    endtask
    task automatic t_timer();
        {board_irq_route_ctl, timer_irq0} = 9'h041;
        cyc(2);
        chk({board_irq_0_oe, board_irq_0_out}, 2'b11);
        timer_irq0 = 1'b0;
        cyc(2);
        chk({board_irq_0_oe, board_irq_0_out}, 2'b10);
        board_irq_route_ctl = 8'h80;
        cyc(2);
        chk(board_irq_0_oe, 1'b0);
        $display("test timer done");
    endtask
    task automatic t_sel(input logic isa, input logic en);
        ext_intc_sel_en = en;
        host_u.mem({ext_intc_base_addr, 8'h44}, isa);
        cyc(2);
        chk(ext_intc_select_n, !(en && !isa));
        if (en && !isa) begin
            chk({isa_addr.drive, isa_addr.la, isa_addr.sa[19:2]}, 26'h2000011);
            chk(xcvr, 4'h0);
        end
        host_u.idle();
        cyc(2);
        chk({ext_intc_select_n, xcvr}, 5'h1e);
        $display("test select %0d%0d done", isa, en);
    endtask
    // Tests take well under 2000 cycles; the watchdog allows ten times that
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial begin
        cyc(4);
        nrst = 1'b1;
        cyc(3);
        t_els();
        t_edge(5);
        t_edge(12);
        t_level();
        t_dflt();
        t_route();
        t_timer();
        t_sel(1'b0, 1'b1);
        t_sel(1'b1, 1'b1);
        t_sel(1'b0, 1'b0);
        end_sim();
    end
endmodule // itsu_top_bench

//--- verification/itsu_top_props.sv
// Port checker for the trigger and steering unit
`timescale 1ns/1ns
module itsu_chk (
    input wire logic                     clk,
    input wire logic                     nrst,
    input wire logic                     els_master_we,
    input wire logic                     els_slave_we,
    input wire logic [7:0]               els_wdata,
    input wire logic [15:0]              eoi_clear,
    input wire itsu_pkg::itsu_pci_cyc_t  pci_cyc,
    input wire logic [31:8]              ext_intc_base_addr,
    input wire logic                     ext_intc_sel_en,
    input wire logic [7:0]               board_irq_route_ctl,
    input wire logic                     timer_irq0,
    input wire logic [7:0]               edge_level_sel_master,
    input wire logic [7:0]               edge_level_sel_slave,
    input wire logic [15:0]              in_service_bits,
    input wire logic [3:0]               ack_vector,
    input wire logic                     ack_valid,
    input wire logic                     ack_default,
    input wire logic                     board_irq_0_out,
    input wire logic                     board_irq_0_oe,
    input wire logic                     ext_intc_select_n,
    input wire itsu_pkg::itsu_isa_addr_t isa_addr,
    input wire itsu_pkg::itsu_xcvr_t     xcvr
);
    import itsu_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Frame is not part of the hit: the select may only appear for these causes
    wire logic hit = ext_intc_sel_en && pci_cyc.mem_cycle && !pci_cyc.isa_origin
        && pci_cyc.addr[31:8] == ext_intc_base_addr;
    sequence dflt_ack;
        ack_valid && ack_default;
    endsequence
    sequence real_ack;
        ack_valid && !ack_default;
    endsequence
    els_reset_a: assert property (disable iff (1'b0)
        !nrst |=> edge_level_sel_master == 8'h00 && edge_level_sel_slave == 8'h00)
        else $error("edge/level select not cleared by reset");
    els_hold_a: assert property (
        !els_master_we && !els_slave_we |=> $stable(edge_level_sel_master)
        && $stable(edge_level_sel_slave)) else $error("edge/level select moved");
    els_write_a: assert property (
        els_master_we |=> edge_level_sel_master == ($past(els_wdata) & 8'hf8))
        else $error("master edge/level write wrong");
    default_vec_a: assert property (dflt_ack |-> ack_vector == 4'h7)
        else $error("default acknowledge not vector 7");
    keep_isr_a: assert property (
        dflt_ack |-> in_service_bits[7] == $past(in_service_bits[7]) || $past(eoi_clear[7]))
        else $error("default acknowledge touched in-service 7");
    set_isr_a: assert property (real_ack |-> in_service_bits[ack_vector])
        else $error("genuine acknowledge left in-service clear");
    sel_cause_a: assert property (!ext_intc_select_n |-> $past(hit))
        else $error("select without matching PCI memory cycle");
    isa_zero_a: assert property (isa_addr.drive |-> isa_addr.la == 7'h00 &&
        isa_addr.sa[19:16] == 4'h0 && isa_addr.sa[15:2] == $past(pci_cyc.addr[15:2]))
        else $error("forwarded ISA address wrong");
    xcvr_on_a: assert property (!ext_intc_select_n |->
        !xcvr.xbus_xcvr_oe_n && !xcvr.disk_xcvr_oe_n) else $error("transceivers off");
    timer_out_a: assert property ($past(nrst) && $past(board_irq_route_ctl[5]) |->
        board_irq_0_oe && board_irq_0_out == $past(timer_irq0))
        else $error("timer irq 0 not driven out");
endmodule // itsu_chk

bind itsu_top itsu_chk chk_u (.clk, .nrst, .els_master_we, .els_slave_we, .els_wdata,
    .eoi_clear, .pci_cyc, .ext_intc_base_addr, .ext_intc_sel_en, .board_irq_route_ctl,
    .timer_irq0, .edge_level_sel_master, .edge_level_sel_slave, .in_service_bits,
    .ack_vector, .ack_valid, .ack_default, .board_irq_0_out, .board_irq_0_oe,
    .ext_intc_select_n, .isa_addr, .xcvr);
